// *** fer_params.svh ***
`ifndef FER_PARAMS_SVH
`define FER_PARAMS_SVH

// register byte offsets
`define FER_OFF_CTRL0 8'h00
`define FER_OFF_FPCW 8'h04
`define FER_OFF_FPSW 8'h08
`define FER_OFF_IRQ_STAT 8'h0C
`define FER_OFF_IRQ_MASK 8'h10
`define FER_OFF_STATE 8'h14

// control_reg_zero fields
`define FER_CTRL0_NATIVE_BIT 0
`define FER_CTRL0_DEFER_BIT 1

// floating-point status word fields
`define FER_FPSW_SUM_BIT 7
`define FER_EXC_W 6

// event bits of the interrupt status register
`define FER_EV_W 4
`define FER_EV_UNMASKED 0
`define FER_EV_TRAP 1
`define FER_EV_FREEZE 2
`define FER_EV_REQ 3

// reset values
`define FER_FPCW_RST 6'h3F
`define FER_CTRL0_NATIVE_RST 1'b0
`define FER_CTRL0_DEFER_RST 1'b0
`define FER_IRQ_MASK_RST 4'h0

// floating-point error exception vector
`define FER_TRAP_VECTOR 8'h10

`endif

// *** fer_pkg.sv ***
package fer_pkg;

    typedef enum logic [3:0] {
        FER_I_FPWAIT = 4'b0000,
        FER_I_WAIT = 4'b0001,
        FER_I_PACKED = 4'b0010,
        FER_I_INIT = 4'b0011,
        FER_I_CLEX = 4'b0100,
        FER_I_STSW = 4'b0101,
        FER_I_STCW = 4'b0110,
        FER_I_STENV = 4'b0111,
        FER_I_SAVE = 4'b1000,
        FER_I_OTHER = 4'b1001
    } fer_instr_t;

    typedef enum logic {
        FER_RUN = 1'b0,
        FER_FREEZE = 1'b1
    } fer_state_t;

endpackage

// *** fer_sticky.sv ***
`timescale 1ns/1ps
module fer_sticky #(
    parameter int W = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        q_nxt = (q_r & ~clr) | set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// *** fer_ahb_slave.sv ***
`timescale 1ns/1ps
module fer_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] rd_data,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data
);
    logic take;
    logic wpend_r;
    logic wpend_nxt;
    logic [7:0] waddr_r;
    logic [7:0] waddr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic rdy_r;

    // only whole-word transfers are decoded; others complete with no effect
    assign take = hsel && htrans[1] && hready && (hsize == 3'b010);

    always_comb begin
        wpend_nxt = take && hwrite;
        waddr_nxt = take ? haddr[7:0] : waddr_r;
        hrdata_nxt = (take && !hwrite) ? rd_data : 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend_r <= 1'b0;
            waddr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            rdy_r <= 1'b1;
        end else begin
            wpend_r <= wpend_nxt;
            waddr_r <= waddr_nxt;
            hrdata_r <= hrdata_nxt;
            rdy_r <= 1'b1;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = rdy_r;
    assign wr_en = wpend_r;
    assign wr_addr = waddr_r;
    assign wr_data = hwdata;
endmodule

// *** fer_error_report.sv ***
// What this block does
// - control_reg_zero flag one selects native reporting
// - exception unmasked only when mask bit clear
// - native mode sets exception flag and summary
// - native traps vector 16 before waiting instruction
// - non-waiting instructions run without the trap
// - flag zero selects external pin reporting
// - compatibility mode sets flag and summary
// - error pin asserted immediately or deferred
// - compatibility mode stalls before waiting instruction
// - ignore input asserted disregards error conditions in compatibility mode only
// - init, clear, env, save discard pending
`timescale 1ns/1ps
`include "fer_params.svh"
module fer_error_report (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic instr_valid,
    input wire fer_pkg::fer_instr_t instr_class,
    input wire logic exc_valid,
    input wire logic [5:0] exc_flags,
    input wire logic ignore_numeric_error_in_n,
    input wire logic interrupt_request_in,
    output logic instr_accept,
    output logic instr_fault,
    output logic instr_stall,
    output logic fp_error_exception,
    output logic [7:0] exc_vector,
    output logic fp_error_out_n,
    output logic irq
);
    import fer_pkg::*;

    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;

    fer_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .rd_data(rd_data),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // control state
    logic native_r;
    logic native_nxt;
    logic defer_r;
    logic defer_nxt;
    logic [`FER_EXC_W-1:0] mask_r;
    logic [`FER_EXC_W-1:0] mask_nxt;
    logic [`FER_EV_W-1:0] irq_mask_r;
    logic [`FER_EV_W-1:0] irq_mask_nxt;

    // status word: exception flags plus summary in the top bit
    logic [`FER_EXC_W:0] sw_set;
    logic [`FER_EXC_W:0] sw_clr;
    logic [`FER_EXC_W:0] sw_q;
    logic [`FER_EV_W-1:0] ev_set;
    logic [`FER_EV_W-1:0] ev_clr;
    logic [`FER_EV_W-1:0] ev_q;

    fer_sticky #(.W(`FER_EXC_W + 1)) u_sw (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(sw_set),
        .clr(sw_clr),
        .q(sw_q)
    );

    fer_sticky #(.W(`FER_EV_W)) u_ev (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(ev_set),
        .clr(ev_clr),
        .q(ev_q)
    );

    // issue path state
    fer_state_t state_r;
    fer_state_t state_nxt;
    logic accept_r;
    logic accept_nxt;
    logic fault_r;
    logic fault_nxt;
    logic trap_r;
    logic trap_nxt;
    logic stall_r;
    logic stall_nxt;
    logic pin_n_r;
    logic pin_n_nxt;
    logic pin_on;
    logic pin_on_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [7:0] vec_r;
    logic resp_r;

    logic pend;
    logic ignoring;
    logic exc_take;
    logic go;
    logic waiting;
    logic discard;
    logic is_init;
    logic freeze_enter;

    assign pend = sw_q[`FER_EXC_W];
    assign ignoring = !native_r && !ignore_numeric_error_in_n;
    // pin register kept active low so the output leaves a flip-flop directly
    assign pin_on = !pin_n_r;

    always_comb begin
        waiting = 1'b0;
        discard = 1'b0;
        is_init = 1'b0;
        unique case (instr_class)
            FER_I_FPWAIT, FER_I_WAIT, FER_I_PACKED: begin
                waiting = 1'b1;
            end
            FER_I_INIT: begin
                discard = 1'b1;
                is_init = 1'b1;
            end
            FER_I_CLEX, FER_I_STENV, FER_I_SAVE: begin
                discard = 1'b1;
            end
            FER_I_STSW, FER_I_STCW, FER_I_OTHER: begin
                waiting = 1'b0;
            end
            default: begin
                waiting = 1'b0;
            end
        endcase
    end

    // one request per two cycles: the core drops valid after seeing the answer
    assign go = instr_valid && !accept_r && !fault_r && (state_r == FER_RUN);
    assign exc_take = exc_valid && !ignoring;

    always_comb begin
        state_nxt = state_r;
        accept_nxt = 1'b0;
        fault_nxt = 1'b0;
        trap_nxt = 1'b0;
        freeze_enter = 1'b0;
        unique case (state_r)
            FER_RUN: begin
                if (go && waiting && pend && native_r) begin
                    fault_nxt = 1'b1;
                    trap_nxt = 1'b1;
                end else if (go && waiting && pend && !ignoring) begin
                    state_nxt = FER_FREEZE;
                    freeze_enter = 1'b1;
                end else if (go) begin
                    accept_nxt = 1'b1;
                end
            end
            FER_FREEZE: begin
                // the handler clears the summary, or masks errors via the ignore pin
                if (!pend || ignoring || native_r) begin
                    state_nxt = FER_RUN;
                end
            end
        endcase
        stall_nxt = (state_nxt == FER_FREEZE);
    end

    // status word update
    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (exc_take) begin
            sw_set[`FER_EXC_W-1:0] = exc_flags;
            sw_set[`FER_EXC_W] = |(exc_flags & ~mask_r);
        end
        if (go && discard) begin
            sw_clr = '1;
        end
        if (wr_en && wr_addr == `FER_OFF_FPSW) begin
            sw_clr[`FER_EXC_W-1:0] = sw_clr[`FER_EXC_W-1:0] | wr_data[`FER_EXC_W-1:0];
            sw_clr[`FER_EXC_W] = sw_clr[`FER_EXC_W] | wr_data[`FER_FPSW_SUM_BIT];
        end
    end

    // error pin: immediate unless deferral is chosen, then at the freeze
    always_comb begin
        pin_on_nxt = 1'b0;
        if (!native_r && pend) begin
            pin_on_nxt = pin_on || (!ignoring && (!defer_r || freeze_enter));
        end
        if (go && discard) begin
            pin_on_nxt = 1'b0;
        end
        pin_n_nxt = !pin_on_nxt;
    end

    // events and interrupt
    always_comb begin
        ev_set = '0;
        ev_set[`FER_EV_UNMASKED] = sw_set[`FER_EXC_W] && !pend;
        ev_set[`FER_EV_TRAP] = fault_nxt;
        ev_set[`FER_EV_FREEZE] = freeze_enter;
        // the controller answers the error pin on the request input
        ev_set[`FER_EV_REQ] = (state_r == FER_FREEZE) && interrupt_request_in;
        ev_clr = '0;
        if (wr_en && wr_addr == `FER_OFF_IRQ_STAT) begin
            ev_clr = wr_data[`FER_EV_W-1:0];
        end
        irq_nxt = |(ev_q & irq_mask_r);
    end

    // software-written control
    always_comb begin
        native_nxt = native_r;
        defer_nxt = defer_r;
        mask_nxt = mask_r;
        irq_mask_nxt = irq_mask_r;
        if (wr_en) begin
            unique case (wr_addr)
                `FER_OFF_CTRL0: begin
                    native_nxt = wr_data[`FER_CTRL0_NATIVE_BIT];
                    defer_nxt = wr_data[`FER_CTRL0_DEFER_BIT];
                end
                `FER_OFF_FPCW: begin
                    mask_nxt = wr_data[`FER_EXC_W-1:0];
                end
                `FER_OFF_IRQ_MASK: begin
                    irq_mask_nxt = wr_data[`FER_EV_W-1:0];
                end
                default: begin
                    mask_nxt = mask_r;
                end
            endcase
        end
        if (go && is_init) begin
            mask_nxt = `FER_FPCW_RST;
        end
    end

    // read mux on the address phase; unmapped offsets read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (haddr[7:0])
            `FER_OFF_CTRL0: begin
                rd_data[`FER_CTRL0_NATIVE_BIT] = native_r;
                rd_data[`FER_CTRL0_DEFER_BIT] = defer_r;
            end
            `FER_OFF_FPCW: begin
                rd_data[`FER_EXC_W-1:0] = mask_r;
            end
            `FER_OFF_FPSW: begin
                rd_data[`FER_EXC_W-1:0] = sw_q[`FER_EXC_W-1:0];
                rd_data[`FER_FPSW_SUM_BIT] = pend;
            end
            `FER_OFF_IRQ_STAT: begin
                rd_data[`FER_EV_W-1:0] = ev_q;
            end
            `FER_OFF_IRQ_MASK: begin
                rd_data[`FER_EV_W-1:0] = irq_mask_r;
            end
            `FER_OFF_STATE: begin
                rd_data[4:0] = {stall_r, pin_on, ignoring, interrupt_request_in, state_r};
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            native_r <= `FER_CTRL0_NATIVE_RST;
            defer_r <= `FER_CTRL0_DEFER_RST;
            mask_r <= `FER_FPCW_RST;
            irq_mask_r <= `FER_IRQ_MASK_RST;
            state_r <= FER_RUN;
            accept_r <= 1'b0;
            fault_r <= 1'b0;
            trap_r <= 1'b0;
            stall_r <= 1'b0;
            pin_n_r <= 1'b1;
            irq_r <= 1'b0;
            vec_r <= `FER_TRAP_VECTOR;
            resp_r <= 1'b0;
        end else begin
            native_r <= native_nxt;
            defer_r <= defer_nxt;
            mask_r <= mask_nxt;
            irq_mask_r <= irq_mask_nxt;
            state_r <= state_nxt;
            accept_r <= accept_nxt;
            fault_r <= fault_nxt;
            trap_r <= trap_nxt;
            stall_r <= stall_nxt;
            pin_n_r <= pin_n_nxt;
            irq_r <= irq_nxt;
            vec_r <= `FER_TRAP_VECTOR;
            resp_r <= 1'b0;
        end
    end

    assign instr_accept = accept_r;
    assign instr_fault = fault_r;
    assign instr_stall = stall_r;
    assign fp_error_exception = trap_r;
    assign exc_vector = vec_r;
    assign fp_error_out_n = pin_n_r;
    assign irq = irq_r;
    assign hresp = resp_r;
endmodule

// *** fer_error_report_props.sv ***
`timescale 1ns/1ps
module fer_error_report_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic instr_valid,
    input wire fer_pkg::fer_instr_t instr_class,
    input wire logic ignore_numeric_error_in_n,
    input wire logic instr_accept,
    input wire logic instr_fault,
    input wire logic instr_stall,
    input wire logic fp_error_exception,
    input wire logic [7:0] exc_vector,
    input wire logic fp_error_out_n
);
    import fer_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_vector_fixed: assert property (exc_vector == 8'h10)
        else $error("trap vector wrong");
    a_trap_pair: assert property (instr_fault == fp_error_exception)
        else $error("trap and exception pulses differ");
    a_nowait_runs: assert property (instr_valid && !instr_stall && !instr_accept && !instr_fault
        && (instr_class inside {FER_I_INIT, FER_I_CLEX, FER_I_STSW, FER_I_STCW, FER_I_STENV,
        FER_I_SAVE}) |=> instr_accept)
        else $error("non-waiting instruction not accepted next cycle");
    a_answer_next: assert property ($rose(instr_valid) && !instr_stall
        |=> instr_accept || instr_fault || instr_stall)
        else $error("instruction not answered next cycle");
    a_native_quiet: assert property (instr_fault |-> fp_error_out_n)
        else $error("error pin driven in native mode");
    a_stall_pin: assert property (instr_stall |-> !fp_error_out_n && !instr_accept
        && !instr_fault)
        else $error("stall without error pin or with an answer");
    a_ignore_quiet: assert property (!ignore_numeric_error_in_n
        && $past(!ignore_numeric_error_in_n) && $past(!ignore_numeric_error_in_n, 2)
        && fp_error_out_n |=> fp_error_out_n)
        else $error("error pin asserted while ignoring");
    a_ignore_thaw: assert property (!ignore_numeric_error_in_n && instr_stall
        |-> ##[1:2] !instr_stall)
        else $error("stall kept while ignoring");
    a_accept_pulse: assert property (instr_accept |=> !instr_accept)
        else $error("accept wider than one cycle");
    c_trap: cover property (instr_fault);
    c_freeze: cover property ($rose(instr_stall));
    c_pin_accept: cover property (!fp_error_out_n && instr_accept);
endmodule

bind fer_error_report fer_error_report_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .instr_valid(instr_valid), .instr_class(instr_class),
    .ignore_numeric_error_in_n(ignore_numeric_error_in_n), .instr_accept(instr_accept),
    .instr_fault(instr_fault), .instr_stall(instr_stall),
    .fp_error_exception(fp_error_exception), .exc_vector(exc_vector),
    .fp_error_out_n(fp_error_out_n)
);

// *** fer_glue_pic.sv ***
`timescale 1ns/1ps
module fer_glue_pic (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fp_error_out_n,
    input wire logic ignore_req,
    input wire logic slow,
    output logic interrupt_request_in,
    output logic ignore_numeric_error_in_n,
    output logic [7:0] irq_type
);
    logic [2:0] line_cnt_r;
    logic [2:0] line_cnt_nxt;
    logic ign_n_r;
    // line 13 must stay up for the programmed delay before the controller fires
    always_comb begin
        line_cnt_nxt = 3'h0;
        if (!fp_error_out_n) begin
            line_cnt_nxt = (line_cnt_r == 3'h7) ? line_cnt_r : line_cnt_r + 3'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_cnt_r <= 3'h0;
            ign_n_r <= 1'b1;
        end else begin
            line_cnt_r <= line_cnt_nxt;
            ign_n_r <= !ignore_req;
        end
    end
    assign interrupt_request_in = line_cnt_r > (slow ? 3'h3 : 3'h0);
    assign irq_type = interrupt_request_in ? 8'h75 : 8'h00;
    assign ignore_numeric_error_in_n = ign_n_r;
endmodule

// *** tb_fer_error_report.sv ***
`timescale 1ns/1ps
`include "fer_params.svh"
module tb_fer_error_report;
    import fer_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic instr_valid = 1'b0;
    fer_instr_t instr_class = FER_I_OTHER;
    logic exc_valid = 1'b0;
    logic [5:0] exc_flags = 6'h00;
    logic ign_req = 1'b0;
    logic slow = 1'b0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, ign_n, req, accept, fault, stall, pin_n, irq, fpx;
    logic [7:0] vec, itype;
    logic [3:0] r;
    fer_instr_t disc[4] = '{FER_I_CLEX, FER_I_STENV, FER_I_SAVE, FER_I_INIT};
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #4 hclk = ~hclk;

    fer_error_report u_fer_error_report (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .instr_valid(instr_valid), .instr_class(instr_class), .exc_valid(exc_valid),
        .exc_flags(exc_flags), .ignore_numeric_error_in_n(ign_n),
        .interrupt_request_in(req), .instr_accept(accept), .instr_fault(fault),
        .instr_stall(stall), .fp_error_exception(fpx), .exc_vector(vec),
        .fp_error_out_n(pin_n), .irq(irq));
    fer_glue_pic u_fer_glue_pic (.hclk(hclk), .hresetn(hresetn), .fp_error_out_n(pin_n),
        .ignore_req(ign_req), .slow(slow), .interrupt_request_in(req),
        .ignore_numeric_error_in_n(ign_n), .irq_type(itype));

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // zero wait states are not assumed: both phases wait for ready
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0000_0000);
        check($sformatf("reg %h", a), rd, e);
    endtask

    task automatic exc(input logic [5:0] f);
        exc_valid <= 1'b1;
        exc_flags <= f;
        @(posedge hclk);
        exc_valid <= 1'b0;
        @(posedge hclk);
    endtask

    // r collects {exception, stall seen, fault, accept}; valid held until the answer
    task automatic ins(input fer_instr_t c);
        instr_valid <= 1'b1;
        instr_class <= c;
        r = 4'b0000;
        for (int i = 0; i < 24 && !(r[0] || r[1]); i++) begin
            @(posedge hclk);
            #1;
            r = r | {fpx, stall, fault, accept};
        end
        @(posedge hclk);
        instr_valid <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(`FER_OFF_CTRL0, 32'h0000_0000);
        rdc(`FER_OFF_FPCW, 32'h0000_003F);
        rdc(`FER_OFF_FPSW, 32'h0000_0000);
        rdc(`FER_OFF_IRQ_MASK, 32'h0000_0000);
        bus(8'h18, 1'b1, 32'hFFFF_FFFF);
        rdc(8'h18, 32'h0000_0000);
        $display("test reset_values done");

        bus(`FER_OFF_CTRL0, 1'b1, 32'h0000_0001);
        bus(`FER_OFF_FPCW, 1'b1, 32'h0000_003E);
        exc(6'h02);
        rdc(`FER_OFF_FPSW, 32'h0000_0002);
        ins(FER_I_FPWAIT);
        check("masked wait", 32'(r), 32'h0000_0001);
        exc(6'h01);
        rdc(`FER_OFF_FPSW, 32'h0000_0083);
        ins(FER_I_STSW);
        check("store status", 32'(r), 32'h0000_0001);
        ins(FER_I_STCW);
        check("store control", 32'(r), 32'h0000_0001);
        for (int i = 0; i < 3; i++) begin
            ins(fer_instr_t'(4'(i)));
            check("trap", 32'(r), 32'h0000_000A);
            check("native pin", 32'(pin_n), 32'h0000_0001);
        end
        check("vector", 32'(vec), 32'h0000_0010);
        rdc(`FER_OFF_IRQ_STAT, 32'h0000_0003);
        bus(`FER_OFF_IRQ_STAT, 1'b1, 32'h0000_000F);
        rdc(`FER_OFF_IRQ_STAT, 32'h0000_0000);
        foreach (disc[i]) begin
            exc(6'h01);
            ins(disc[i]);
            check("discard run", 32'(r), 32'h0000_0001);
            rdc(`FER_OFF_FPSW, 32'h0000_0000);
        end
        rdc(`FER_OFF_FPCW, 32'h0000_003F);
        ins(FER_I_FPWAIT);
        check("after discard", 32'(r), 32'h0000_0001);
        $display("test native done");

        bus(`FER_OFF_FPCW, 1'b1, 32'h0000_003E);
        bus(`FER_OFF_CTRL0, 1'b1, 32'h0000_0000);
        bus(`FER_OFF_IRQ_MASK, 1'b1, 32'h0000_0001);
        slow <= 1'b1;
        exc(6'h01);
        settle(2);
        check("immediate pin", 32'(pin_n), 32'h0000_0000);
        @(posedge hclk);
        rdc(`FER_OFF_FPSW, 32'h0000_0081);
        settle(6);
        check("request", 32'(req), 32'h0000_0001);
        check("irq type", 32'(itype), 32'h0000_0075);
        check("irq up", 32'(irq), 32'h0000_0001);
        @(posedge hclk);
        bus(`FER_OFF_IRQ_STAT, 1'b1, 32'h0000_0001);
        settle(2);
        check("irq cleared", 32'(irq), 32'h0000_0000);
        @(posedge hclk);
        fork
            ins(FER_I_WAIT);
            begin
                repeat (4) @(posedge hclk);
                bus(`FER_OFF_FPSW, 1'b1, 32'h0000_0080);
            end
        join
        check("freeze then run", 32'(r), 32'h0000_0005);
        settle(1);
        check("pin released", 32'(pin_n), 32'h0000_0001);
        @(posedge hclk);
        rdc(`FER_OFF_FPSW, 32'h0000_0001);
        $display("test compat_immediate done");

        ign_req <= 1'b1;
        ins(FER_I_CLEX);
        exc(6'h01);
        settle(3);
        check("ignored pin", 32'(pin_n), 32'h0000_0001);
        @(posedge hclk);
        rdc(`FER_OFF_FPSW, 32'h0000_0000);
        rdc(`FER_OFF_STATE, 32'h0000_0004);
        ins(FER_I_WAIT);
        check("ignored wait", 32'(r), 32'h0000_0001);
        ign_req <= 1'b0;
        $display("test ignore done");

        bus(`FER_OFF_CTRL0, 1'b1, 32'h0000_0002);
        slow <= 1'b0;
        exc(6'h01);
        settle(3);
        check("deferred pin", 32'(pin_n), 32'h0000_0001);
        @(posedge hclk);
        fork
            ins(FER_I_PACKED);
            begin
                repeat (4) @(posedge hclk);
                ign_req <= 1'b1;
            end
        join
        check("thaw by ignore", 32'(r), 32'h0000_0005);
        ign_req <= 1'b0;
        settle(1);
        check("pin held", 32'(pin_n), 32'h0000_0000);
        @(posedge hclk);
        ins(FER_I_CLEX);
        settle(2);
        check("pin after clear", 32'(pin_n), 32'h0000_0001);
        @(posedge hclk);
        $display("test compat_deferred done");
        conclude();
    end
endmodule
